// [rtl/fts_pkg.sv]
// shared widths, reset values and carrier types of the flow-through burst memory core
package fts_pkg;
    // wide variant: 512K words of four 9-bit lanes (8 data bits plus one parity_lane bit)
    localparam int FTS_ADDR_W = 19;
    localparam int FTS_LANES = 4;
    localparam int FTS_LANE_W = 9;
    localparam int FTS_DATA_W = FTS_LANES * FTS_LANE_W;
    localparam int FTS_WORDS = 1 << FTS_ADDR_W;
    localparam int FTS_FIFO_DEPTH = 8;
    // burst wraps inside a group of four words
    localparam int FTS_BURST_W = 2;
    localparam logic [FTS_BURST_W-1:0] FTS_BURST_ONE = 2'h1;
    localparam logic [FTS_BURST_W-1:0] FTS_BURST_RST = 2'h0;
    // reset values
    localparam logic [FTS_DATA_W-1:0] FTS_DOUT_RST = 36'h0_0000_0000;
    localparam logic [FTS_ADDR_W-1:0] FTS_ADDR_RST = 19'h0_0000;
    localparam logic [FTS_LANES-1:0] FTS_LANES_RST = 4'h0;
    localparam logic FTS_OE_N_RST = 1'b1;
    localparam logic FTS_SLEEP_RST = 1'b1;

    // operation carried by the registered address cycle
    typedef enum logic [1:0] {FTS_IDLE, FTS_READ, FTS_WRITE} fts_op_t;

    // one posted write: address, lanes to update, data
    typedef struct packed {
        logic [FTS_ADDR_W-1:0] addr;
        logic [FTS_LANES-1:0] lanes;
        logic [FTS_DATA_W-1:0] data;
    } fts_wr_t;

    // cycle state of the core; the array, posting fifo and reset synchroniser are kept apart
    typedef struct packed {
        fts_op_t op;
        logic [FTS_ADDR_W-1:0] addr;
        logic [FTS_BURST_W-1:0] start_lo;
        logic [FTS_BURST_W-1:0] count;
        logic wr_pend;
        logic [FTS_ADDR_W-1:0] wr_addr;
        logic [FTS_LANES-1:0] wr_lanes;
        logic [FTS_DATA_W-1:0] dout;
        logic dq_oe_n;
        logic power_down;
        logic order_meta;
        logic order_sync;
    } fts_state_t;
endpackage

// [rtl/fts_fifo.sv]
// small write-posting fifo with a view of every stored entry, oldest first
`timescale 1ns/1ps
module fts_fifo
    import fts_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [DEPTH-1:0][WIDTH-1:0] peek,
    output logic [DEPTH-1:0] peek_valid
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    typedef struct packed {
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [PW:0] count;
        logic not_full;
    } fts_fifo_state_t;

    // empty and ready to accept; ready must come up high out of reset
    localparam fts_fifo_state_t STATE_RST = '{rd_ptr: '0, wr_ptr: '0, count: '0, not_full: 1'b1};

    fts_fifo_state_t state_reg;
    fts_fifo_state_t state_next;
    logic [WIDTH-1:0] store [DEPTH];
    logic push;
    logic pop;

    // not-full is kept as its own flop so in_ready leaves straight from a register
    assign in_ready = state_reg.not_full;
    assign out_valid = (state_reg.count != '0);
    assign out_data = store[state_reg.rd_ptr];
    assign push = in_valid & state_reg.not_full;
    assign pop = out_valid & out_ready;

    // pointer and count update; pointers wrap at depth even when it is not a power of two
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.wr_ptr = (state_reg.wr_ptr == PTR_LAST) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == PTR_LAST) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
        state_next.not_full = (state_next.count != FULL_COUNT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // storage has no reset; only entries below count are ever looked at
    always_ff @(posedge clk) begin
        if (push) begin
            store[state_reg.wr_ptr] <= in_data;
        end
    end

    // entry view in age order so a reader can merge older before newer
    always_comb begin
        logic [PW:0] idx;
        idx = '0;
        for (int i = 0; i < DEPTH; i++) begin
            idx = (PW+1)'(state_reg.rd_ptr) + (PW+1)'(i);
            if (idx >= FULL_COUNT) begin
                idx = idx - FULL_COUNT;
            end
            peek[i] = store[idx[PW-1:0]];
            peek_valid[i] = ((PW+1)'(i) < state_reg.count);
        end
    end
endmodule

// [rtl/fts_core.sv]
// flow-through burst static memory core with posted writes and byte-lane selects
// How it works
// [R1] every synchronous pin is captured on the rising edge of CORE_CLK
// [R2] clock qualifier high freezes all state but the output-enable flop and the mode synchroniser, stretching the previous cycle
// [R3] reads and writes may follow each other on every enabled clock
// [R4] array holds 512K words of 36 bits
// [R5] write strobe low plus lane selects pick which byte lanes are written
// [R6] data drivers are off during the data phase of every write
// [R7] selected only when both active-low and the active-high select agree; OE gates output
// [R8] read word appears right after the edge that registers its address
// [R9] burst order linear or interleaved, chosen by a static mode input
// [R10] sleep or deselect drops into low power; release resumes operation
// [R11] advance high continues the burst, advance low loads address and command
// [R12] bursts wrap in four words: linear adds, interleaved xors the count
`timescale 1ns/1ps
module fts_core
    import fts_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [FTS_ADDR_W-1:0] ADDR,
    input wire logic CHIP_SELECT_A_N,
    input wire logic CHIP_SELECT_B,
    input wire logic CHIP_SELECT_C_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [FTS_LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
    input wire logic CLOCK_QUALIFIER_N,
    input wire logic ADVANCE_OR_LOAD,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQUEST,
    input wire logic BURST_ORDER_INTERLEAVED,
    input wire logic [FTS_DATA_W-1:0] DQ_IN,
    output logic [FTS_DATA_W-1:0] DQ_OUT,
    output logic DQ_OE_N,
    output logic WRITE_READY,
    output logic POWER_DOWN
);
    localparam int WR_W = $bits(fts_wr_t);

    logic [1:0] rst_sync_reg;
    logic rst_n;
    fts_state_t state_reg;
    fts_state_t state_next;
    logic [FTS_DATA_W-1:0] mem [FTS_WORDS];

    logic enabled;
    logic selected;
    logic [FTS_BURST_W-1:0] count_step;
    logic [FTS_BURST_W-1:0] burst_lo;
    logic [FTS_ADDR_W-1:0] acc_addr;
    logic [FTS_DATA_W-1:0] read_word;
    fts_wr_t push_entry;
    fts_wr_t drain_entry;
    fts_wr_t peek_entry;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic [WR_W-1:0] drain_flat;
    logic [FTS_FIFO_DEPTH-1:0][WR_W-1:0] peek;
    logic [FTS_FIFO_DEPTH-1:0] peek_valid;

    // overlay the chosen lanes of data onto base
    function automatic logic [FTS_DATA_W-1:0] fts_merge(
        input logic [FTS_DATA_W-1:0] base,
        input logic [FTS_DATA_W-1:0] data,
        input logic [FTS_LANES-1:0] lanes
    );
        logic [FTS_DATA_W-1:0] word;
        word = base;
        for (int l = 0; l < FTS_LANES; l++) begin
            if (lanes[l]) begin
                word[l*FTS_LANE_W +: FTS_LANE_W] = data[l*FTS_LANE_W +: FTS_LANE_W];
            end
        end
        return word;
    endfunction

    // reset enters asynchronously but is released through two flops
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // a stalled clock freezes the cycle state: one enable gates all updates but the output-enable flop and mode synchroniser
    assign enabled = ~CLOCK_QUALIFIER_N; // [R2]
    assign selected = ~CHIP_SELECT_A_N & CHIP_SELECT_B & ~CHIP_SELECT_C_N; // [R7]

    // next burst address inside the four-word group
    assign count_step = state_reg.count + FTS_BURST_ONE; // [R12]
    assign burst_lo = state_reg.order_sync ? (state_reg.start_lo ^ count_step)
                                           : (state_reg.start_lo + count_step); // [R9] [R12]

    // address of the access taken at this edge; a load reads the pins directly,
    // which equals registering the address and letting the array flow through
    always_comb begin
        if (!ADVANCE_OR_LOAD) begin
            acc_addr = ADDR; // [R11]
        end else begin
            acc_addr = {state_reg.addr[FTS_ADDR_W-1:FTS_BURST_W], burst_lo}; // [R11] [R12]
        end
    end

    // the array read sees older posted writes in age order, then this edge's data phase,
    // so a read right behind a write never returns stale data
    always_comb begin
        read_word = mem[acc_addr];
        for (int i = 0; i < FTS_FIFO_DEPTH; i++) begin
            peek_entry = fts_wr_t'(peek[i]);
            if (peek_valid[i] && peek_entry.addr == acc_addr) begin
                read_word = fts_merge(read_word, peek_entry.data, peek_entry.lanes); // [R3]
            end
        end
        if (state_reg.wr_pend && state_reg.wr_addr == acc_addr) begin
            read_word = fts_merge(read_word, DQ_IN, state_reg.wr_lanes); // [R3]
        end
    end

    // data phase of a registered write posts one entry; a full buffer drops it,
    // which the controller avoids by watching WRITE_READY
    assign push_valid = enabled & state_reg.wr_pend; // [R5]
    assign push_entry.addr = state_reg.wr_addr;
    assign push_entry.lanes = state_reg.wr_lanes;
    assign push_entry.data = DQ_IN;

    // main sequencing: capture pins, load or advance, read, start data phases
    always_comb begin
        state_next = state_reg;
        // mode pin is a static strap from outside, so it is synchronised
        state_next.order_meta = BURST_ORDER_INTERLEAVED;
        state_next.order_sync = state_reg.order_meta;
        if (enabled) begin // [R1] [R2]
            state_next.wr_pend = 1'b0;
            if (!ADVANCE_OR_LOAD) begin
                state_next.addr = ADDR; // [R1]
                state_next.start_lo = ADDR[FTS_BURST_W-1:0];
                state_next.count = FTS_BURST_RST;
                if (SLEEP_REQUEST || !selected) begin
                    state_next.op = FTS_IDLE; // [R7] [R10]
                end else if (!WRITE_STROBE_N) begin
                    state_next.op = FTS_WRITE; // [R5]
                end else begin
                    state_next.op = FTS_READ;
                end
            end else if (SLEEP_REQUEST) begin
                state_next.op = FTS_IDLE; // [R10]
            end else if (state_reg.op != FTS_IDLE) begin
                state_next.addr = acc_addr; // [R11]
                state_next.count = count_step; // [R12]
            end
            state_next.power_down = (state_next.op == FTS_IDLE); // [R10]
            unique case (state_next.op)
                FTS_READ: begin
                    state_next.dout = read_word; // [R8]
                end
                FTS_WRITE: begin
                    state_next.wr_pend = 1'b1; // [R3]
                    state_next.wr_addr = acc_addr;
                    state_next.wr_lanes = ~BYTE_LANE_WRITE_SELECT_N; // [R1] [R5]
                end
                FTS_IDLE: begin
                end
            endcase
        end
        // drivers only on for a read cycle with output enable low; held off for writes
        state_next.dq_oe_n = (state_next.op != FTS_READ) | OUTPUT_ENABLE_N; // [R6] [R7]
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.op <= FTS_IDLE;
            state_reg.addr <= FTS_ADDR_RST;
            state_reg.start_lo <= FTS_BURST_RST;
            state_reg.count <= FTS_BURST_RST;
            state_reg.wr_pend <= 1'b0;
            state_reg.wr_addr <= FTS_ADDR_RST;
            state_reg.wr_lanes <= FTS_LANES_RST;
            state_reg.dout <= FTS_DOUT_RST;
            state_reg.dq_oe_n <= FTS_OE_N_RST;
            state_reg.power_down <= FTS_SLEEP_RST;
            state_reg.order_meta <= 1'b0;
            state_reg.order_sync <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // the array has one port: a read taken at this edge wins, draining waits,
    // so a long run of reads lets the posted writes pile up
    assign drain_ready = enabled & (state_next.op != FTS_READ);
    assign drain_entry = fts_wr_t'(drain_flat);

    fts_fifo #(
        .WIDTH(WR_W),
        .DEPTH(FTS_FIFO_DEPTH)
    ) u_post (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_entry),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_flat),
        .peek(peek),
        .peek_valid(peek_valid)
    );

    // self-timed array update: only the selected lanes change
    always_ff @(posedge CORE_CLK) begin
        if (drain_valid && drain_ready) begin
            for (int l = 0; l < FTS_LANES; l++) begin
                if (drain_entry.lanes[l]) begin // [R4] [R5]
                    mem[drain_entry.addr][l*FTS_LANE_W +: FTS_LANE_W] <=
                        drain_entry.data[l*FTS_LANE_W +: FTS_LANE_W];
                end
            end
        end
    end

    assign DQ_OUT = state_reg.dout;
    assign DQ_OE_N = state_reg.dq_oe_n;
    assign POWER_DOWN = state_reg.power_down;
    assign WRITE_READY = push_ready;
endmodule

// [testbench/fts_core_chk.sv]
// pin-level checks of the flow-through burst memory core
`timescale 1ns/1ps
module fts_core_chk
    import fts_pkg::*;
(
    input logic CORE_CLK,
    input logic RSTN,
    input logic [FTS_ADDR_W-1:0] ADDR,
    input logic CHIP_SELECT_A_N,
    input logic CHIP_SELECT_B,
    input logic CHIP_SELECT_C_N,
    input logic WRITE_STROBE_N,
    input logic [FTS_LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
    input logic CLOCK_QUALIFIER_N,
    input logic ADVANCE_OR_LOAD,
    input logic OUTPUT_ENABLE_N,
    input logic SLEEP_REQUEST,
    input logic BURST_ORDER_INTERLEAVED,
    input logic [FTS_DATA_W-1:0] DQ_IN,
    input logic [FTS_DATA_W-1:0] DQ_OUT,
    input logic DQ_OE_N,
    input logic WRITE_READY,
    input logic POWER_DOWN
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // decoded cycle kinds; a qualified-off edge is no cycle at all
    wire en = !CLOCK_QUALIFIER_N;
    wire sel = !CHIP_SELECT_A_N && CHIP_SELECT_B && !CHIP_SELECT_C_N;
    wire ld = en && !ADVANCE_OR_LOAD && !SLEEP_REQUEST && sel;
    wire rd = ld && WRITE_STROBE_N && !OUTPUT_ENABLE_N;
    wire wr = ld && !WRITE_STROBE_N;
    wire adv = en && ADVANCE_OR_LOAD && !SLEEP_REQUEST && !OUTPUT_ENABLE_N;
    // two-step transfers: write then read, read then burst advance
    sequence s_wr_rd; wr ##1 rd; endsequence
    sequence s_rd_adv; rd ##1 adv; endsequence
    property p_wr_off; wr |=> DQ_OE_N; endproperty
    a_wr_off: assert property (p_wr_off) else $error("drivers on in write");
    property p_rd_on; rd |=> !DQ_OE_N && !POWER_DOWN; endproperty
    a_rd_on: assert property (p_rd_on) else $error("read not driven");
    property p_stall; !en |=> $stable(DQ_OUT) && $stable(DQ_OE_N) && $stable(POWER_DOWN);
    endproperty
    a_stall: assert property (p_stall) else $error("state moved in stall");
    property p_hold; wr |=> DQ_OUT == $past(DQ_OUT); endproperty
    a_hold: assert property (p_hold) else $error("read data lost in write");
    property p_sleep; en && SLEEP_REQUEST |=> POWER_DOWN && DQ_OE_N; endproperty
    a_sleep: assert property (p_sleep) else $error("awake in sleep");
    property p_desel; en && !ADVANCE_OR_LOAD && !CHIP_SELECT_B && WRITE_STROBE_N |=> POWER_DOWN;
    endproperty
    a_desel: assert property (p_desel) else $error("awake when deselected");
    property p_desel_any; en && !ADVANCE_OR_LOAD && !sel |=> POWER_DOWN && DQ_OE_N;
    endproperty
    a_desel_any: assert property (p_desel_any) else $error("select off, awake");
    property p_wr_rd; s_wr_rd |=> !DQ_OE_N; endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("turnaround cycle");
    property p_rd_adv; s_rd_adv |=> !DQ_OE_N && !POWER_DOWN; endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("burst stopped");
    property p_oe; ld && WRITE_STROBE_N && OUTPUT_ENABLE_N |=> DQ_OE_N; endproperty
    a_oe: assert property (p_oe) else $error("drive without enable");
endmodule
bind fts_core fts_core_chk chk_u (.*);

// [testbench/fts_ctrl_model.sv]
// controller model driving synchronous accesses into the memory core
`timescale 1ns/1ps
module fts_ctrl_model
    import fts_pkg::*;
(
    input logic CORE_CLK,
    input logic WRITE_READY,
    output logic [FTS_ADDR_W-1:0] ADDR,
    output logic CHIP_SELECT_A_N,
    output logic CHIP_SELECT_B,
    output logic CHIP_SELECT_C_N,
    output logic WRITE_STROBE_N,
    output logic [FTS_LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
    output logic CLOCK_QUALIFIER_N,
    output logic ADVANCE_OR_LOAD,
    output logic OUTPUT_ENABLE_N,
    output logic SLEEP_REQUEST,
    output logic [FTS_DATA_W-1:0] DQ_IN
);
    logic wr_prev = 1'b0;
    logic [1:0] desel_sel = 2'h0;
    // c holds qualifier-off, sleep, output-off, deselect
    task automatic put(input logic [3:0] c, input logic adv, we_n,
            input logic [FTS_ADDR_W-1:0] a, input logic [FTS_LANES-1:0] bl,
            input logic [FTS_DATA_W-1:0] d);
        CLOCK_QUALIFIER_N = c[3];
        SLEEP_REQUEST = c[2];
        OUTPUT_ENABLE_N = c[1];
        // deselect rotates through each of the three select lines in turn
        {CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N} = !c[0] ? 3'h2 :
            (desel_sel == 2'h0) ? 3'h0 : (desel_sel == 2'h1) ? 3'h6 : 3'h3;
        if (c[0]) desel_sel = (desel_sel == 2'h2) ? 2'h0 : desel_sel + 2'h1;
        ADVANCE_OR_LOAD = adv;
        WRITE_STROBE_N = we_n;
        ADDR = a;
        BYTE_LANE_WRITE_SELECT_N = bl;
        // data only in a write data phase; elsewhere a toggling pattern, never a stale word
        DQ_IN = (wr_prev && WRITE_READY) ? d : ~DQ_IN;
        // an advance keeps a write burst writing; sleep, or a load while deselected, ends it
        if (!c[3]) wr_prev = !c[2] && (adv ? wr_prev : (!we_n && !c[0]));
    endtask
    // one cycle: pins set just after an edge, held to the next, answer read 1 ns on
    task automatic step(input logic [3:0] c, input logic adv, we_n,
            input logic [FTS_ADDR_W-1:0] a, input logic [FTS_LANES-1:0] bl,
            input logic [FTS_DATA_W-1:0] d);
        put(c, adv, we_n, a, bl, d);
        @(posedge CORE_CLK);
        #1;
    endtask
    // deselected and quiet at time zero
    initial begin
        DQ_IN = 36'h0_0000_0000;
        put(4'h1, 1'b0, 1'b1, 19'h0_0000, 4'hf, 36'h0_0000_0000);
    end
endmodule

// [testbench/tb_fts_core.sv]
// self-checking bench for the flow-through burst memory core
`timescale 1ns/1ps
module tb_fts_core
    import fts_pkg::*;
;
    localparam logic [3:0] GO = 4'h0;
    localparam logic [3:0] STALL = 4'h8;
    localparam logic [3:0] DES = 4'h1;
    logic CORE_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic BURST_ORDER_INTERLEAVED = 1'b0;
    logic [FTS_ADDR_W-1:0] ADDR;
    logic CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N, WRITE_STROBE_N;
    logic CLOCK_QUALIFIER_N, ADVANCE_OR_LOAD, OUTPUT_ENABLE_N, SLEEP_REQUEST;
    logic [FTS_LANES-1:0] BYTE_LANE_WRITE_SELECT_N, bl;
    logic [FTS_DATA_W-1:0] DQ_IN, DQ_OUT, d;
    logic DQ_OE_N, WRITE_READY, POWER_DOWN;
    logic [FTS_DATA_W-1:0] mem [8];
    int miscompares = 0;
    int comparisons = 0;

    fts_core dut_u (.*);
    fts_ctrl_model ctl_u (.*);
    always #5 CORE_CLK = ~CORE_CLK;

    // slot j maps to the bottom or the very top burst group
    function automatic logic [FTS_ADDR_W-1:0] adr(input int j);
        return j[2] ? {17'h1_ffff, j[1:0]} : {17'h0_0000, j[1:0]};
    endfunction
    // selected lanes take new data, the rest keep the old word
    function automatic logic [FTS_DATA_W-1:0] merge(input logic [FTS_DATA_W-1:0] o, n,
            input logic [FTS_LANES-1:0] s);
        for (int l = 0; l < FTS_LANES; l++) begin
            if (!s[l]) o[l*FTS_LANE_W +: FTS_LANE_W] = n[l*FTS_LANE_W +: FTS_LANE_W];
        end
        return o;
    endfunction
    // k-th word of a burst that wraps inside its group of four
    function automatic logic [1:0] nxt(input logic [1:0] s, k, input logic il);
        return il ? s ^ k : s + k;
    endfunction
    task automatic check(input logic [FTS_DATA_W-1:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hang ends the run as a failure
    initial begin
        #1000000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        void'($urandom(43));
        repeat (3) @(posedge CORE_CLK);
        #1 RSTN = 1'b1;
        repeat (2) @(posedge CORE_CLK);
        #1;
        // full words first, then random lane writes each read back on the next edge
        for (int i = 0; i < 48; i++) begin
            bl = (i < 8) ? 4'h0 : FTS_LANES'($urandom());
            d = FTS_DATA_W'({$urandom(), $urandom()});
            ctl_u.step(GO, 1'b0, 1'b0, adr(i % 8), bl, d);
            ctl_u.step(GO, 1'b0, 1'b1, adr(i % 8), 4'hf, d);
            mem[i % 8] = merge(mem[i % 8], d, bl);
            check(DQ_OUT, mem[i % 8], "write then read");
            check(DQ_OE_N, 1'b0, "read drive");
            check(WRITE_READY, 1'b1, "no write wait");
        end
        $display("test lane writes done");
        // every start word of both groups, in both burst orders
        for (int il = 0; il < 2; il++) begin
            BURST_ORDER_INTERLEAVED = il[0];
            repeat (3) ctl_u.step(DES, 1'b0, 1'b1, adr(0), 4'hf, 36'h0_0000_0000);
            for (int s = 0; s < 8; s++) begin
                for (int k = 0; k < 4; k++) begin
                    ctl_u.step(GO, k != 0, 1'b1, k ? ~adr(s) : adr(s), 4'hf, '0);
                    check(DQ_OUT, mem[{s[2], nxt(s[1:0], k[1:0], il[0])}], "burst");
                end
            end
        end
        $display("test bursts done");
        // a stall holds the output and the burst position
        ctl_u.step(GO, 1'b0, 1'b1, adr(0), 4'hf, '0);
        repeat (3) ctl_u.step(STALL, 1'b0, 1'b0, adr(7), 4'h0, '0);
        check(DQ_OUT, mem[0], "stalled output");
        ctl_u.step(GO, 1'b1, 1'b1, adr(7), 4'hf, '0);
        check(DQ_OUT, mem[1], "advance after stall");
        $display("test stall done");
        // write burst over the top group by advancing, then read it back as a burst
        for (int k = 0; k < 8; k++) begin
            d = FTS_DATA_W'({$urandom(), $urandom()});
            if (k inside {[1:4]}) mem[3 + k] = d;
            ctl_u.step(GO, k % 4 != 0, k >= 4, adr(4), 4'h0, d);
            if (k >= 4) check(DQ_OUT, mem[k], "burst write");
        end
        $display("test burst write done");
        // sleep, output-off and deselect on each select line, each followed by a read
        for (int m = 0; m < 5; m++) begin
            ctl_u.step((m < 3) ? 4'h4 >> m : DES, 1'b0, 1'b1, adr(m), 4'hf, '0);
            check(POWER_DOWN, m != 1, "low power");
            check(DQ_OE_N, 1'b1, "drivers off");
            ctl_u.step(GO, 1'b0, 1'b1, adr(m), 4'hf, '0);
            check(POWER_DOWN, 1'b0, "resumed");
            check(DQ_OUT, mem[m], "read after release");
        end
        $display("test power done");
        report_and_stop();
    end
endmodule
